// ===== src/pibarb_arbiter.sv
// pibarb_arbiter: priority interrupt unit with break multiplexer
// assumes memory control pulses memCycleDone once per granted break cycle
// and the core supplies state words; levels sampled on sampleTick
`timescale 1ns/10ps
module pibarb_arbiter #(
  parameter int NLEV = pibarb_pkg::NUM_LEVELS,
  parameter int NCH  = pibarb_pkg::NUM_CHAN
) (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              sampleTick,
  input  wire logic [NLEV-1:0]                   extLevelRequest,
  input  wire logic [NCH-1:0]                    extBreakReq,
  input  wire logic                              intrInhibit,
  input  wire logic                              flagA,
  input  wire logic                              jumpReturnInhibitInstr,
  input  wire logic                              dataInstrFieldInstr,
  input  wire logic                              loadInstrFieldInstr,
  input  wire logic                              restoreCmd,
  input  wire logic                              memCycleDone,
  input  wire logic [pibarb_pkg::ADDR_W-1:0]     stackBase,
  input  wire logic                              stackLoad,
  input  wire logic [pibarb_pkg::ADDR_W-1:0]     vectorBase,
  input  wire logic                              levelAck,
  input  wire logic [pibarb_pkg::WORD_W-1:0]     memReadData,
  output logic [pibarb_pkg::LEVEL_W-1:0]         trialLevelCode,
  output logic [pibarb_pkg::LEVEL_W-1:0]         presentLevel,
  output logic                                   priorityAccepted,
  output logic                                   pushSeqFf,
  output logic                                   intrBreakReqFf,
  output logic                                   intrReqAccepted,
  output logic                                   muxIntrReqFf,
  output logic                                   muxIntrGrant,
  output logic                                   muxBreakGrant,
  output logic [NCH-1:0]                         channelBreakEnable,
  output logic [pibarb_pkg::ADDR_W-1:0]          stackAddr,
  output logic                                   stackWrite,
  output logic [pibarb_pkg::SLOT_W-1:0]          saveSlot,
  output logic                                   pcLoad,
  output logic [pibarb_pkg::ADDR_W-1:0]          pcVector,
  output logic                                   restoreLoad,
  output logic [pibarb_pkg::WORD_W-1:0]          restoreData
);

  // all state of the arbiter in one record
  typedef struct packed {
    logic [NLEV-1:0]                     levelRequestFf;  // latched levels
    logic [pibarb_pkg::LEVEL_W-1:0]      trial;      // registered trial
    logic [pibarb_pkg::LEVEL_W-1:0]      present;    // present level
    logic [pibarb_pkg::LEVEL_W-1:0]      pending;    // level being pushed
    logic                                prioOk;     // accepted flag
    logic                                push;       // push sequence flop
    logic                                restore;    // restore flop
    logic                                brkReq;     // interrupt break req
    logic                                reqOk;      // request accepted
    logic                                muxIntr;    // mux interrupt flop
    logic                                grantI;     // interrupt grant
    logic                                grantB;     // data break grant
    logic [NCH-1:0]                      chanEn;     // per-channel enable
    pibarb_pkg::pibarb_seq_t             seq;        // sequencer state
    logic [pibarb_pkg::SLOT_W-1:0]       slot;       // cycle within push or pop
    logic [pibarb_pkg::ADDR_W-1:0]       sp;         // stack pointer
    logic                                wr;         // write strobe level
    logic                                pcLd;       // vector load pulse
    logic [pibarb_pkg::ADDR_W-1:0]       vec;        // vector address
    logic                                rdLd;       // restore load pulse
    logic [pibarb_pkg::WORD_W-1:0]       rdData;     // restored word
  } pibarb_st_t;
  pibarb_st_t st_q, st_d;

  logic [NLEV-1:0]                levSync;    // synchronised levels
  logic [NCH-1:0]                 brkSync;    // synchronised break lines
  logic                           anyLevel;   // some level requesting
  logic [pibarb_pkg::LEVEL_W-1:0] encCode;    // encoder output
  logic                           cpuOk;      // processor not critical
  logic                           anyBreak;   // any data break pending
  logic                           newerWins;  // strict priority compare

  // lowest set index wins; used for channel choice
  function automatic logic [NCH-1:0] pickFirst(input logic [NCH-1:0] v);
    logic [NCH-1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : pickFirst

  // level pins come from other devices, so synchronise them
  pibarb_sync #(.W(NLEV)) uLevSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (extLevelRequest),
    .syncOut  (levSync)
  );

  // break request pins, same treatment
  pibarb_sync #(.W(NCH)) uBrkSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (extBreakReq),
    .syncOut  (brkSync)
  );

  pibarb_prio_enc #(.N(NLEV)) uEnc (
    .reqVec (st_q.levelRequestFf),
    .anyReq (anyLevel),
    .code   (encCode)
  );

  // qualifying terms
  always_comb begin
    cpuOk = !intrInhibit && flagA && !jumpReturnInhibitInstr &&
            !dataInstrFieldInstr && !loadInstrFieldInstr;
    anyBreak = |brkSync;
    // new minus present must be negative
    newerWins = anyLevel &&
      ($signed({1'b0, st_q.trial}) - $signed({1'b0, st_q.present}) < 0);
  end

  // next-state logic
  always_comb begin
    st_d      = st_q;
    st_d.pcLd = 1'b0;
    st_d.rdLd = 1'b0;

    // levels latch at the timing pulse; a serviced level
    // clears on acknowledge, but a request in the same cycle wins
    if (levelAck) begin
      st_d.levelRequestFf[st_q.pending] = 1'b0;
    end
    if (sampleTick) begin
      st_d.levelRequestFf = st_d.levelRequestFf | levSync;
    end
    st_d.trial = anyLevel ? encCode : pibarb_pkg::CPU_LEVEL;

    // accepted level; push sets once idle
    st_d.prioOk = newerWins;
    if (st_q.prioOk && newerWins && st_q.seq == pibarb_pkg::PIB_IDLE &&
        !st_q.push && !st_q.restore) begin
      st_d.push    = 1'b1;
      st_d.pending = st_q.trial;
    end
    if (restoreCmd && !st_q.push && st_q.seq == pibarb_pkg::PIB_IDLE) begin
      st_d.restore = 1'b1;
    end

    // push or restore raises break request
    st_d.brkReq = st_q.push || st_q.restore;
    // break request gated by processor status
    st_d.reqOk = st_q.brkReq && cpuOk;
    // accepted request sets mux interrupt flop
    if (st_q.reqOk) begin
      st_d.muxIntr = 1'b1;
    end

    // data break lines, line 0 first
    st_d.chanEn = pickFirst(brkSync);
    st_d.grantB = anyBreak;
    // interrupt only when all lines quiet
    st_d.grantI = st_q.muxIntr && !anyBreak;

    if (stackLoad && st_q.seq == pibarb_pkg::PIB_IDLE) begin
      st_d.sp = stackBase;
    end

    unique case (st_q.seq)
      pibarb_pkg::PIB_IDLE: begin
        st_d.slot = pibarb_pkg::SLOT_ZERO;
        if (st_q.grantI) begin
          st_d.seq = st_q.push ? pibarb_pkg::PIB_PUSH : pibarb_pkg::PIB_POP;
          st_d.wr  = st_q.push;
          if (!st_q.push) begin
            st_d.sp = st_q.sp - pibarb_pkg::ADDR_ONE;
          end
        end
      end
      pibarb_pkg::PIB_PUSH: begin
        if (memCycleDone) begin
          // vector on second cycle; per level
          if (st_q.slot == pibarb_pkg::VEC_SLOT) begin
            st_d.pcLd = 1'b1;
            st_d.vec  = vectorBase |
              (pibarb_pkg::ADDR_W'(st_q.pending) << pibarb_pkg::VEC_LVL_LSB);
          end
          st_d.sp = st_q.sp + pibarb_pkg::ADDR_ONE;
          if (st_q.slot == pibarb_pkg::LAST_SLOT) begin
            st_d.seq     = pibarb_pkg::PIB_IDLE;
            st_d.wr      = 1'b0;
            st_d.push    = 1'b0;
            st_d.muxIntr = 1'b0;
            st_d.grantI  = 1'b0;
            st_d.brkReq  = 1'b0;
            st_d.reqOk   = 1'b0;
            st_d.present = st_q.pending;
          end else begin
            st_d.slot = st_q.slot + 3'h1;
          end
        end
      end
      pibarb_pkg::PIB_POP: begin
        if (memCycleDone) begin
          st_d.rdLd   = 1'b1;
          st_d.rdData = memReadData;
          if (st_q.slot == pibarb_pkg::LAST_SLOT) begin
            st_d.seq     = pibarb_pkg::PIB_IDLE;
            st_d.restore = 1'b0;
            st_d.muxIntr = 1'b0;
            st_d.grantI  = 1'b0;
            st_d.brkReq  = 1'b0;
            st_d.reqOk   = 1'b0;
            // pointer back at the popped frame base
            st_d.present = pibarb_pkg::LEVEL_W'(memReadData);
          end else begin
            st_d.sp   = st_q.sp - pibarb_pkg::ADDR_ONE;
            st_d.slot = st_q.slot + 3'h1;
          end
        end
      end
      // spare code of the two-bit state field: fall back to idle
      default: begin
        st_d.seq = pibarb_pkg::PIB_IDLE;
      end
    endcase
  end

  // reset clears flops, level returns to processor
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q         <= '0;
      st_q.present <= pibarb_pkg::CPU_LEVEL;
      st_q.trial   <= pibarb_pkg::CPU_LEVEL;
      st_q.seq     <= pibarb_pkg::PIB_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state record
  assign trialLevelCode     = st_q.trial;
  assign presentLevel       = st_q.present;
  assign priorityAccepted   = st_q.prioOk;
  assign pushSeqFf          = st_q.push;
  assign intrBreakReqFf     = st_q.brkReq;
  assign intrReqAccepted    = st_q.reqOk;
  assign muxIntrReqFf       = st_q.muxIntr;
  assign muxIntrGrant       = st_q.grantI;
  assign muxBreakGrant      = st_q.grantB;
  assign channelBreakEnable = st_q.chanEn;
  assign stackAddr          = st_q.sp;
  assign stackWrite         = st_q.wr;
  assign saveSlot           = st_q.slot;
  assign pcLoad             = st_q.pcLd;
  assign pcVector           = st_q.vec;
  assign restoreLoad        = st_q.rdLd;
  assign restoreData        = st_q.rdData;

  // checks
  // reset state
  chk_reset_level: assert property (@(posedge core_clk)
    sys_rst |=> presentLevel == pibarb_pkg::CPU_LEVEL && !pushSeqFf)
    else $error("present level not processor after reset");
  chk_grant_strict: assert property (@(posedge core_clk)
    disable iff (sys_rst) priorityAccepted |->
    $past(trialLevelCode) < $past(presentLevel))
    else $error("grant without strictly higher level");
  chk_push_brkreq: assert property (@(posedge core_clk)
    disable iff (sys_rst) $rose(pushSeqFf) |=> intrBreakReqFf)
    else $error("push did not raise break request");
  chk_cpu_critical: assert property (@(posedge core_clk)
    disable iff (sys_rst) intrReqAccepted |-> $past(cpuOk))
    else $error("accepted while processor critical");
  chk_mux_set: assert property (@(posedge core_clk)
    disable iff (sys_rst) intrReqAccepted &&
    !(memCycleDone && saveSlot == pibarb_pkg::LAST_SLOT) |=> muxIntrReqFf)
    else $error("mux interrupt flop not set");
  // no interrupt grant with breaks pending
  chk_break_first: assert property (@(posedge core_clk)
    disable iff (sys_rst) $rose(muxIntrGrant) |-> !$past(anyBreak))
    else $error("interrupt granted over data break");
  chk_chan_onehot: assert property (@(posedge core_clk)
    disable iff (sys_rst) $onehot0(channelBreakEnable) &&
    (muxBreakGrant == |channelBreakEnable))
    else $error("channel enables not one-hot");
  // pointer steps up on push cycle
  chk_push_incr: assert property (@(posedge core_clk)
    disable iff (sys_rst) st_q.seq == pibarb_pkg::PIB_PUSH && memCycleDone
    |=> stackAddr == $past(stackAddr) + pibarb_pkg::ADDR_ONE)
    else $error("stack pointer not incremented");
  // vector load only on second cycle
  chk_vec_slot: assert property (@(posedge core_clk)
    disable iff (sys_rst) pcLoad |-> $past(saveSlot) == pibarb_pkg::VEC_SLOT)
    else $error("vector loaded on wrong cycle");
  chk_pop_decr: assert property (@(posedge core_clk)
    disable iff (sys_rst) st_q.seq == pibarb_pkg::PIB_POP && memCycleDone &&
    saveSlot != pibarb_pkg::LAST_SLOT
    |=> stackAddr == $past(stackAddr) - pibarb_pkg::ADDR_ONE)
    else $error("stack pointer not decremented");

  cov_push: cover property (@(posedge core_clk) $fell(pushSeqFf));
  cov_pop: cover property (@(posedge core_clk) $fell(st_q.restore));
  cov_break: cover property (@(posedge core_clk) muxBreakGrant &&
    muxIntrReqFf);
  cov_vector: cover property (@(posedge core_clk) pcLoad);
endmodule : pibarb_arbiter

// ===== inc/pibarb_pkg.sv
// pibarb_pkg: constants and types for the priority interrupt break arbiter
// assumes a 12-bit processor word, 15-bit stack and vector addresses
package pibarb_pkg;
  localparam int NUM_LEVELS   = 15;          // external request levels
  localparam int LEVEL_W      = 4;           // level code width
  localparam int NUM_CHAN     = 3;           // data break channels
  localparam int WORD_W       = 12;          // processor word width
  localparam int ADDR_W       = 15;          // field plus address
  localparam int PUSH_CYCLES  = 5;           // memory cycles per push/pop
  localparam int SLOT_W       = 3;           // slot counter width
  localparam logic [LEVEL_W-1:0] CPU_LEVEL = 4'hF;  // octal 17, lowest
  localparam logic [SLOT_W-1:0]  LAST_SLOT = 3'h4;  // fifth cycle index
  localparam logic [SLOT_W-1:0]  VEC_SLOT  = 3'h1;  // second push cycle
  localparam logic [SLOT_W-1:0]  SLOT_ZERO = 3'h0;  // first cycle index
  localparam logic [ADDR_W-1:0]  ADDR_ONE  = 15'h0001; // stack step
  localparam int VEC_LVL_LSB  = 1;           // level sits above bit 0
  localparam int PREWIRED_SRC = 9;           // levels for prewired options

  // break cycle sequencer states
  typedef enum logic [1:0] {
    PIB_IDLE,
    PIB_PUSH,
    PIB_POP
  } pibarb_seq_t;
endpackage : pibarb_pkg

// ===== src/pibarb_prio_enc.sv
// pibarb_prio_enc: lowest-index-wins encoder over the request flops
// assumes purely combinational use inside the arbiter
`timescale 1ns/10ps
module pibarb_prio_enc #(
  parameter int N = pibarb_pkg::NUM_LEVELS
) (
  input  wire logic [N-1:0]                     reqVec,
  output logic                                  anyReq,
  output logic [pibarb_pkg::LEVEL_W-1:0]        code
);
  // scan from lowest priority up so level 0 ends up winning
  always_comb begin
    anyReq = 1'b0;
    code   = pibarb_pkg::CPU_LEVEL;
    for (int i = N - 1; i >= 0; i--) begin
      if (reqVec[i]) begin
        anyReq = 1'b1;
        code   = pibarb_pkg::LEVEL_W'(i);
      end
    end
  end
endmodule : pibarb_prio_enc

// ===== src/pibarb_sync.sv
// pibarb_sync: three-stage synchroniser with agreement filter
// assumes async inputs; output changes once stages two and three agree
`timescale 1ns/10ps
module pibarb_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } pibarb_sync_st_t;
  pibarb_sync_st_t st_q, st_d;

  // only s2 reads s1; filter looks at s2 and s3
  always_comb begin
    st_d     = st_q;
    st_d.s1  = asyncIn;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign syncOut = st_q.out;
endmodule : pibarb_sync

// ===== verif/pibarb_mem_model.sv
// pibarb_mem_model: stack memory and cycle control beside the arbiter
// assumes grant stands for a whole push or pop and drops after cycle five
`timescale 1ns/10ps
module pibarb_mem_model (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          muxIntrGrant,
  input  wire logic                          stackWrite,
  input  wire logic [pibarb_pkg::ADDR_W-1:0] stackAddr,
  input  wire logic [pibarb_pkg::LEVEL_W-1:0] presentLevel,
  input  wire logic                          slowMode,
  output logic                               memCycleDone,
  output logic [pibarb_pkg::WORD_W-1:0]      memReadData
);
  logic [11:0] memQ [16];  // stack image, low address bits only
  logic [3:0]  waitQ;      // cycles since grant or last memory cycle

  // one memory cycle per wait period while the interrupt grant stands
  always @(posedge core_clk) begin
    memCycleDone <= 1'b0;
    // released bus flips every cycle, never holds the last word
    memReadData  <= ~memReadData;
    if (sys_rst) begin
      waitQ       <= 4'h0;
      memReadData <= 12'h000;
    end else if (!muxIntrGrant || memCycleDone) begin
      waitQ <= 4'h0;
    end else if (waitQ >= (slowMode ? 4'h6 : 4'h3)) begin
      // gap of three or more keeps a sixth cycle from slipping in
      memCycleDone <= 1'b1;
      waitQ        <= 4'h0;
      if (stackWrite) begin
        memQ[stackAddr[3:0]] <= {8'h5A, presentLevel};
      end else begin
        // pop reads the word at the pointer
        memReadData <= memQ[stackAddr[3:0]];
      end
    end else begin
      waitQ <= waitQ + 4'h1;
    end
  end
endmodule : pibarb_mem_model

// ===== verif/pibarb_arbiter_tb.sv
// pibarb_arbiter_tb: directed sequences of level, break and restore calls
// assumes the memory model answers every granted break cycle
`timescale 1ns/10ps
module pibarb_arbiter_tb;
  logic        core_clk, sys_rst, sampleTick, restoreCmd, stackLoad;
  logic        intrInhibit, flagA, jumpReturnInhibitInstr;
  logic        dataInstrFieldInstr, loadInstrFieldInstr, levelAck;
  logic [14:0] extLevelRequest, stackBase, vectorBase, stackAddr, pcVector;
  logic [2:0]  extBreakReq, channelBreakEnable, saveSlot;
  logic [3:0]  trialLevelCode, presentLevel;
  logic        priorityAccepted, pushSeqFf, intrBreakReqFf, intrReqAccepted;
  logic        muxIntrReqFf, muxIntrGrant, muxBreakGrant, stackWrite;
  logic        pcLoad, restoreLoad, memCycleDone, slowMode;
  logic [11:0] memReadData, restoreData;
  int          fail_count, checks, cyc, doneCnt, rlCnt, pcAt; // tallies
  logic [14:0] pcVec;     // vector seen at the pc load

  pibarb_arbiter i_pibarb_arbiter (
    .core_clk (core_clk), .sys_rst (sys_rst), .sampleTick (sampleTick),
    .extLevelRequest (extLevelRequest), .extBreakReq (extBreakReq),
    .intrInhibit (intrInhibit), .flagA (flagA),
    .jumpReturnInhibitInstr (jumpReturnInhibitInstr),
    .dataInstrFieldInstr (dataInstrFieldInstr),
    .loadInstrFieldInstr (loadInstrFieldInstr), .restoreCmd (restoreCmd),
    .memCycleDone (memCycleDone), .stackBase (stackBase),
    .stackLoad (stackLoad), .vectorBase (vectorBase), .levelAck (levelAck),
    .memReadData (memReadData), .trialLevelCode (trialLevelCode),
    .presentLevel (presentLevel), .priorityAccepted (priorityAccepted),
    .pushSeqFf (pushSeqFf), .intrBreakReqFf (intrBreakReqFf),
    .intrReqAccepted (intrReqAccepted), .muxIntrReqFf (muxIntrReqFf),
    .muxIntrGrant (muxIntrGrant), .muxBreakGrant (muxBreakGrant),
    .channelBreakEnable (channelBreakEnable), .stackAddr (stackAddr),
    .stackWrite (stackWrite), .saveSlot (saveSlot), .pcLoad (pcLoad),
    .pcVector (pcVector), .restoreLoad (restoreLoad),
    .restoreData (restoreData)
  );
  pibarb_mem_model i_pibarb_mem_model (
    .core_clk (core_clk), .sys_rst (sys_rst), .muxIntrGrant (muxIntrGrant),
    .stackWrite (stackWrite), .stackAddr (stackAddr),
    .presentLevel (presentLevel), .slowMode (slowMode),
    .memCycleDone (memCycleDone), .memReadData (memReadData)
  );

  always #2 core_clk = ~core_clk;

  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [14:0] e, g);
    checks++;
    if (e !== g) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // one bit per critical condition of the processor
  task automatic setStat(input logic [4:0] b);
    intrInhibit            <= b[0];
    flagA                  <= !b[1];
    jumpReturnInhibitInstr <= b[2];
    dataInstrFieldInstr    <= b[3];
    loadInstrFieldInstr    <= b[4];
  endtask : setStat

  // drop the pin first so the set cannot win over the clear
  task automatic ackLevel(input int l);
    extLevelRequest[l] <= 1'b0;
    tick(8);
    levelAck <= 1'b1;
    tick(1);
    levelAck <= 1'b0;
    tick(8);
  endtask : ackLevel

  // waits out one push or pop and checks where it left the unit
  task automatic expectSeq(input logic [3:0] l, input logic [14:0] a,
                           input logic pop);
    int n;
    logic seen;
    n = 0;
    doneCnt = 0;
    rlCnt = 0;
    if (pop) begin
      restoreCmd <= 1'b1;
      tick(1);
      restoreCmd <= 1'b0;
    end
    while (muxIntrGrant !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    seen = muxIntrGrant;
    while (muxIntrGrant !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    tick(3);
    chk("grantSeen", 15'h0001, {14'h0, seen});
    chk("memCycles", 15'h0005, 15'(doneCnt));
    chk("presentLevel", {11'h0, l}, {11'h0, presentLevel});
    chk("stackAddr", a, stackAddr);
    if (pop) begin
      chk("restoreLoads", 15'h0005, 15'(rlCnt));
      chk("restoreData", {3'h0, 8'h5A, l}, {3'h0, restoreData});
    end else begin
      chk("pcVector", vectorBase | {10'h0, l, 1'b0}, pcVec);
      chk("pcLoadCycle", 15'h0002, 15'(pcAt));
    end
  endtask : expectSeq

  // timing pulse, watchdog and sequence monitor
  always @(posedge core_clk) begin
    cyc        <= cyc + 1;
    sampleTick <= (cyc[1:0] == 2'h3);
    if (memCycleDone) begin
      doneCnt <= doneCnt + 1;
    end
    // pop cycles never write the stack
    if (restoreLoad) begin
      rlCnt <= rlCnt + 1;
      chk("stackWrite", 15'h0000, {14'h0, stackWrite});
    end
    if (pcLoad) begin
      pcAt  <= doneCnt;
      pcVec <= pcVector;
    end
    if (memCycleDone && stackWrite) begin
      chk("saveSlot", 15'(doneCnt), {12'h0, saveSlot});
    end
    // a hang costs a mismatch, then the closing report
    if (cyc == 5000) begin
      fail_count++;
      $display("ERROR cycles expected below 5000 seen %0d", cyc);
      stop_test();
    end
  end

  initial begin
    core_clk = 0; sys_rst = 1; sampleTick = 0; restoreCmd = 0;
    stackLoad = 0; levelAck = 0; extLevelRequest = '0; extBreakReq = '0;
    stackBase = 15'h0100; vectorBase = 15'h2000; slowMode = 0;
    intrInhibit = 0; flagA = 1; jumpReturnInhibitInstr = 0;
    dataInstrFieldInstr = 0; loadInstrFieldInstr = 0;
    fail_count = 0; checks = 0; cyc = 0; doneCnt = 0; rlCnt = 0; pcAt = 0;
    tick(10);
    sys_rst <= 1'b0;
    tick(2);
    chk("presentLevel", 15'h000F, {11'h0, presentLevel});
    chk("trialLevelCode", 15'h000F, {11'h0, trialLevelCode});
    chk("pushSeqFf", 15'h0000, {14'h0, pushSeqFf});
    stackLoad <= 1'b1;
    tick(1);
    stackLoad <= 1'b0;
    // every break pattern: lowest line number wins
    for (int p = 1; p < 8; p++) begin
      extBreakReq <= p[2:0];
      tick(8);
      chk("chanEnable", 15'(p & -p), {12'h0, channelBreakEnable});
      chk("muxBreakGrant", 15'h0001, {14'h0, muxBreakGrant});
    end
    extBreakReq <= 3'h0;
    tick(8);
    chk("muxBreakGrant", 15'h0000, {14'h0, muxBreakGrant});
    // each critical state alone holds the request back
    extLevelRequest[9] <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      setStat(5'h01 << k);
      tick(16);
      chk("trialLevelCode", 15'h0009, {11'h0, trialLevelCode});
      chk("priorityAccepted", 15'h1, {14'h0, priorityAccepted});
      chk("intrBreakReqFf", 15'h1, {14'h0, intrBreakReqFf});
      chk("intrReqAccepted", 15'h0, {14'h0, intrReqAccepted});
    end
    // break line passes its synchroniser before the status clears
    extBreakReq <= 3'h4;
    tick(8);
    setStat(5'h00);
    tick(16);
    chk("muxIntrReqFf", 15'h1, {14'h0, muxIntrReqFf});
    chk("muxIntrGrant", 15'h0, {14'h0, muxIntrGrant});
    chk("chanEnable", 15'h4, {12'h0, channelBreakEnable});
    extBreakReq <= 3'h0;
    expectSeq(4'h9, 15'h0105, 1'b0);
    ackLevel(9);
    // equal level is refused
    extLevelRequest[9] <= 1'b1;
    tick(16);
    chk("priorityAccepted", 15'h0, {14'h0, priorityAccepted});
    ackLevel(9);
    // nested push with slow memory, lowest level left waiting
    slowMode <= 1'b1;
    extLevelRequest[3]  <= 1'b1;
    extLevelRequest[14] <= 1'b1;
    expectSeq(4'h3, 15'h010A, 1'b0);
    ackLevel(3);
    chk("trialLevelCode", 15'h000E, {11'h0, trialLevelCode});
    chk("priorityAccepted", 15'h0, {14'h0, priorityAccepted});
    expectSeq(4'h9, 15'h0105, 1'b1);
    expectSeq(4'hF, 15'h0100, 1'b1);
    // level fourteen still beats the processor level
    expectSeq(4'hE, 15'h0105, 1'b0);
    ackLevel(14);
    stop_test();
  end
endmodule : pibarb_arbiter_tb
